// ===== rtl/jcd_counter.sv
/*
 * Johnson counter with fully decoded one-hot outputs and cascade output.
 * Assumes clk_sys far faster than the counting clock pin, so every pin
 * level lasts at least three system clock cycles.
 */
// Notes on behaviour
// - Five stages give ten outputs; four stages give eight outputs.
// - Each rising count clock edge advances one step while hold is low.
// - While hold is high, count clock edges leave the state unchanged.
// - A high counter reset forces the zero count.
// - Exactly one decoded output is high at any time.
// - A decoded output stays high for one full counting clock period.
// - Each decoded output comes from a two-input gate of adjacent stages.
// - Cascade completes one period per full count cycle, ten or eight.
// - Cascade rising edge serves as clock for the next counter.
// - Illegal Johnson states are steered back into the legal sequence.
// - Clock held high, falling hold pulses advance the count.
// - Clearing to zero raises the zero-count decoded output.
`timescale 1ns/100ps
`default_nettype none
module jcd_counter #(
  parameter int STAGES = jcd_pkg::JCD_DECADE_STAGES
) (
  // System clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Counter pins, asynchronous to clk_sys
  input wire jcd_pkg::jcd_pins_type pins,
  // Decoded one-hot outputs and cascade output
  output logic [2*STAGES-1:0] decoded_pin,
  output logic cascade_pulse_pin
);
  import jcd_pkg::*;

  localparam int OUTS = 2 * STAGES;

  typedef struct packed {
    jcd_pins_type [JCD_SYNC_DEPTH-1:0] sync;
    logic gate_prev;
    logic [STAGES-1:0] stage;
    logic [OUTS-1:0] decoded;
    logic cascade;
  } jcd_state_type;

  jcd_state_type s;
  jcd_state_type next_s;
  jcd_pins_type pin_now;
  logic gate_now;
  logic fire;

  // Legal Johnson states are a run of ones from the bottom or from the top
  function automatic logic is_legal(input logic [STAGES-1:0] q);
    logic ok;
    ok = 1'b1;
    for (int i = 1; i < STAGES; i++) begin
      if (q[0] && !q[i - 1] && q[i]) begin
        ok = 1'b0;
      end
      if (!q[0] && q[i - 1] && !q[i]) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  // One Johnson step, with anti-lock recovery to count zero
  function automatic logic [STAGES-1:0] step(input logic [STAGES-1:0] q);
    if (!is_legal(q)) begin
      return {STAGES{JCD_STAGE_RESET}};
    end
    return {q[STAGES-2:0], ~q[STAGES-1]};
  endfunction

  // Two-input decode of adjacent stages keeps outputs free of spikes
  function automatic logic [OUTS-1:0] decode(input logic [STAGES-1:0] q);
    logic [OUTS-1:0] d;
    d = '0;
    d[0] = ~q[0] & ~q[STAGES-1];
    d[STAGES] = q[0] & q[STAGES-1];
    for (int k = 1; k < STAGES; k++) begin
      d[k] = q[k - 1] & ~q[k];
      d[STAGES + k] = ~q[k - 1] & q[k];
    end
    return d;
  endfunction

  // Second synchroniser stage is the only one the logic reads
  assign pin_now = s.sync[JCD_SYNC_DEPTH-1];
  // Clock gated by hold; its rising edge covers both clocking styles
  assign gate_now = pin_now.count_clk & ~pin_now.count_hold;
  assign fire = gate_now & ~s.gate_prev;

  // Next state
  always_comb begin
    next_s = s;
    next_s.sync = {s.sync[JCD_SYNC_DEPTH-2:0], pins};
    next_s.gate_prev = gate_now;
    if (pin_now.count_reset) begin
      next_s.stage = {STAGES{JCD_STAGE_RESET}};
    end else if (fire) begin
      next_s.stage = step(s.stage);
    end
    // Outputs follow the stages in the same edge so they stay registered
    next_s.decoded = decode(next_s.stage);
    next_s.cascade = ~next_s.stage[STAGES-1];
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s.sync <= '0;
      s.gate_prev <= 1'b0;
      s.stage <= {STAGES{JCD_STAGE_RESET}};
      s.decoded <= {{(OUTS-1){1'b0}}, 1'b1};
      s.cascade <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign decoded_pin = s.decoded;
  assign cascade_pulse_pin = s.cascade;

  // Checks
  // Exactly one output high, also straight after reset
  onehot_decode_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $onehot(decoded_pin))
    else $error("decoded outputs not one-hot");

  // A detected edge moves the stages one Johnson step
  advance_step_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (fire && !pin_now.count_reset) |=> s.stage == step($past(s.stage)))
    else $error("count did not advance one step");

  // No edge, no change: hold and idle clock both freeze the count
  hold_freeze_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!fire && !pin_now.count_reset) |=> $stable(s.stage))
    else $error("count changed without a clock edge");

  // Counter reset lands on count zero one edge later
  reset_zero_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    pin_now.count_reset |=> s.stage == '0 && decoded_pin[0])
    else $error("reset did not reach count zero");

  // Outputs stand from one advance to the next
  decode_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ##1 (!$past(fire) && !$past(pin_now.count_reset)) |-> $stable(decoded_pin))
    else $error("decoded output changed mid period");

  // Recovery path: an illegal pattern returns to zero on the next edge
  antilock_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (fire && !pin_now.count_reset && !is_legal(s.stage)) |=> s.stage == '0)
    else $error("illegal state not recovered");

  // Cascade high exactly while one of the first half outputs is high
  cascade_half_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    cascade_pulse_pin == (decoded_pin[STAGES-1:0] != '0))
    else $error("cascade not high in first half");

  // Cascade rise seen across two samples
  sequence cascade_rise_s;
    !cascade_pulse_pin ##1 cascade_pulse_pin;
  endsequence

  cascade_zero_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    cascade_rise_s |-> decoded_pin[0])
    else $error("cascade rose away from count zero");

  // Clock held high: a falling hold acts as the counting edge
  falling_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (pin_now.count_clk && $past(pin_now.count_clk) && !pin_now.count_hold
     && $past(pin_now.count_hold) && !pin_now.count_reset)
    |=> s.stage != $past(s.stage))
    else $error("falling hold did not advance");

  // Stage register never leaves the legal Johnson ring
  stage_legal_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    is_legal(s.stage))
    else $error("stage register in an illegal state");

  // Outputs follow the stages through the two-input decode only
  decode_match_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    decoded_pin == decode(s.stage))
    else $error("decoded outputs disagree with stages");

  // A change without reset is a step to the neighbouring output
  sequence step_seen_s;
    $changed(decoded_pin) && !$past(pin_now.count_reset);
  endsequence

  // Rotating the new outputs back by one gives the old ones: no skipping
  decode_walk_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    step_seen_s |->
      {decoded_pin[0], decoded_pin[OUTS-1:1]} == $past(decoded_pin))
    else $error("decoded outputs skipped a count");

  // Cascade falls exactly when the second half of the cycle begins
  cascade_fall_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $fell(cascade_pulse_pin) |-> decoded_pin[STAGES])
    else $error("cascade fell away from the half count");

  // Clock edges while reset stays high leave the count parked at zero;
  // the reset branch is tested first so an edge can never slip through
  reset_park_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (pin_now.count_reset && fire) |=> decoded_pin[0])
    else $error("advance overrode the counter reset");
endmodule // jcd_counter
`default_nettype wire

// ===== rtl/jcd_pkg.sv
/*
 * Shared constants and carrier types for the Johnson counter/decoder.
 * Assumes a single system clock; pin inputs arrive asynchronously.
 */
`default_nettype none
package jcd_pkg;
  // Stage counts of the two variants
  localparam int JCD_DECADE_STAGES = 5;
  localparam int JCD_OCTAL_STAGES = 4;
  // Depth of the pin synchroniser
  localparam int JCD_SYNC_DEPTH = 2;
  // Value of the stages at count zero and after reset
  localparam logic JCD_STAGE_RESET = 1'h0;

  // Pin inputs of the counter, carried together
  typedef struct packed {
    logic count_clk;
    logic count_hold;
    logic count_reset;
  } jcd_pins_type;
endpackage
`default_nettype wire

// ===== tb/jcd_pin_src.sv
/* Pin source for the counter: count clock, hold and reset pins.
   Assumes clk_sys; pins change only at its falling edges. */
`timescale 1ns/100ps
`default_nettype none
module jcd_pin_src (
  // System clock
  input wire logic clk_sys,
  // Pins toward the counter
  output var jcd_pkg::jcd_pins_type pins
);
  import jcd_pkg::*;
  // Reset pin high from time zero keeps both counters quiet
  initial begin
    pins = '{count_clk: 1'h0, count_hold: 1'h0, count_reset: 1'h1};
  end
  // Each level stands four cycles, above the three-cycle minimum
  task automatic drive(input logic c, input logic h, input logic r);
    @(negedge clk_sys);
    pins = '{count_clk: c, count_hold: h, count_reset: r};
    repeat (3) @(negedge clk_sys);
  endtask
endmodule // jcd_pin_src
`default_nettype wire

// ===== tb/tb_jcd_counter.sv
/* Bench: a decade counter whose cascade clocks an octal counter.
   Assumes the pin source model and a 50 MHz system clock. */
`timescale 1ns/100ps
`default_nettype none
module tb_jcd_counter;
  import jcd_pkg::*;
  logic clk_sys = 1'h0;
  logic sys_rst = 1'h1;
  jcd_pins_type pins;
  jcd_pins_type pins2;
  logic [9:0] dec;
  logic [7:0] dec2;
  logic cas;
  logic cas2;
  int err_count = 0;
  int num_checks = 0;
  int n1 = 0;
  int n2 = 0;
  // Selects the zero output as octal clock for short divide cycles
  logic use_zero = 1'h0;
  // Octal counter takes the cascade as its clock, reset is shared;
  // in divide mode the zero output clocks it and its reset stays low
  assign pins2 = '{count_clk: use_zero ? dec[0] : cas, count_hold: 1'h0,
    count_reset: pins.count_reset & ~use_zero};
  jcd_pin_src jcd_pin_src_i (.clk_sys(clk_sys), .pins(pins));
  jcd_counter #(.STAGES(JCD_DECADE_STAGES)) jcd_counter_i (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .pins(pins),
    .decoded_pin(dec), .cascade_pulse_pin(cas));
  jcd_counter #(.STAGES(JCD_OCTAL_STAGES)) jcd_counter_oct_i (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .pins(pins2),
    .decoded_pin(dec2), .cascade_pulse_pin(cas2));
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Settle first: the octal answer trails the cascade by three edges
  task automatic check_all;
    repeat (4) @(negedge clk_sys);
    check({5'h00, cas, dec}, {5'h00, n1 < 5, 10'h001 << n1});
    check({7'h00, cas2, dec2}, {7'h00, n2 < 4, 8'h01 << n2});
  endtask
  task automatic adv;
    n1 = (n1 + 1) % 10;
    if (n1 == 0) begin
      n2 = (n2 + 1) % 8;
    end
  endtask
  task automatic pulse(input logic h, input logic r);
    jcd_pin_src_i.drive(1'h1, h, r);
    jcd_pin_src_i.drive(1'h0, h, r);
    if (!h && !r) begin
      adv();
    end
  endtask
  // Two full decade cycles plus one step: every output at least twice, two octal steps
  task automatic t_count;
    repeat (21) begin
      pulse(1'h0, 1'h0);
      check_all();
    end
  endtask
  // Hold blocks rising edges; with clock high a falling hold counts
  task automatic t_hold;
    repeat (3) begin
      pulse(1'h1, 1'h0);
      check_all();
    end
    jcd_pin_src_i.drive(1'h1, 1'h1, 1'h0);
    jcd_pin_src_i.drive(1'h1, 1'h0, 1'h0);
    adv();
    check_all();
    jcd_pin_src_i.drive(1'h0, 1'h0, 1'h0);
  endtask
  // Reset mid count, then one clock pulse while reset stays high
  task automatic t_reset;
    repeat (3) pulse(1'h0, 1'h0);
    jcd_pin_src_i.drive(1'h0, 1'h0, 1'h1);
    n1 = 0;
    n2 = 0;
    check_all();
    pulse(1'h0, 1'h1);
    check_all();
    jcd_pin_src_i.drive(1'h0, 1'h0, 1'h0);
    pulse(1'h0, 1'h0);
    check_all();
  endtask
  // Divide by four: a latch on output four clears the decade counter,
  // released with the clock low; the zero output clocks the octal one
  task automatic t_divide;
    use_zero = 1'h1;
    repeat (2) begin
      while (n1 != 4) begin
        pulse(1'h0, 1'h0);
      end
      check_all();
      jcd_pin_src_i.drive(1'h0, 1'h0, 1'h1);
      n1 = 0;
      n2 = (n2 + 1) % 8;
      check_all();
      jcd_pin_src_i.drive(1'h0, 1'h0, 1'h0);
    end
    use_zero = 1'h0;
    check_all();
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Whole run is near 480 cycles; the 20000-cycle limit, about forty times that, means a hang
  initial begin
    #400000;
    err_count++;
    final_report();
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    @(negedge clk_sys);
    sys_rst = 1'h0;
    jcd_pin_src_i.drive(1'h0, 1'h0, 1'h0);
    check_all();
    t_count();
    t_hold();
    t_reset();
    t_divide();
    final_report();
  end
endmodule // tb_jcd_counter
`default_nettype wire
